// >>> src/twq_defines.vh
// register offsets, field positions and reset values of the timer block
`ifndef TWQ_DEFINES_VH
`define TWQ_DEFINES_VH
// channel register offsets (within a 0x20 channel window)
`define TWQ_CH_STRIDE    8'h20
`define TWQ_OFF_CMR      5'h00
`define TWQ_OFF_CCR      5'h04
`define TWQ_OFF_RA       5'h08
`define TWQ_OFF_RB       5'h0c
`define TWQ_OFF_RC       5'h10
`define TWQ_OFF_CV       5'h14
`define TWQ_OFF_SR       5'h18
// block register offsets
`define TWQ_OFF_BMR      8'h40
`define TWQ_OFF_BCR      8'h44
`define TWQ_OFF_QSR      8'h48
// channel control bits and block sync bit
`define TWQ_CCR_CLKEN    0
`define TWQ_CCR_CLKDIS   1
`define TWQ_CCR_SWTRG    2
`define TWQ_BCR_SYNC     0
// channel mode fields
`define TWQ_CMR_CLKS     2:0
`define TWQ_CMR_CSTOP    6
`define TWQ_CMR_CDIS     7
`define TWQ_CMR_EDGE     9:8
`define TWQ_CMR_ABSEL    10
`define TWQ_CMR_EVSRC    11:10
`define TWQ_CMR_EVTRG    12
`define TWQ_CMR_WSEL     14:13
`define TWQ_CMR_WAVE     15
`define TWQ_CMR_ACPA     17:16
`define TWQ_CMR_ACPC     19:18
`define TWQ_CMR_AEEVT    21:20
`define TWQ_CMR_ASWTRG   23:22
`define TWQ_CMR_BCPB     25:24
`define TWQ_CMR_BCPC     27:26
`define TWQ_CMR_BEEVT    29:28
`define TWQ_CMR_BSWTRG   31:30
// block mode fields
`define TWQ_BMR_DECODER_ENABLE     0
`define TWQ_BMR_POSEN    1
`define TWQ_BMR_SPEEDEN  2
`define TWQ_BMR_INVERT_PHASE_A     3
`define TWQ_BMR_INVERT_PHASE_B     4
`define TWQ_BMR_INVERT_INDEX   5
`define TWQ_BMR_SWAP     6
`define TWQ_BMR_FILTEN   7
`define TWQ_BMR_XC0ROUTE 8
`define TWQ_BMR_FLEN     15:10
// reset values
`define TWQ_RST_CMR      32'h0000_0000
`define TWQ_RST_BMR      16'h0000
`define TWQ_RST_CNT      16'h0000
`endif

// >>> src/twq_timer.v
// two-channel timer with waveform modes and quadrature decoder front end
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
// ==========================================================
// Notes on behaviour
// [RULE1] capture trigger pin chosen by mode bit
// [RULE2] capture edge field, zero disables trigger
// [RULE3] waveform mode drives two compare outputs
// [RULE4] select 00 counts full range, triggers clear
// [RULE5] period match never triggers in 00/01
// [RULE6] select 10 clears on period match
// [RULE7] period match stops or disables clock
// [RULE8] select 01 counts up then down full
// [RULE9] select 11 counts up to period, down
// [RULE10] trigger reverses up-down counting direction
// [RULE11] event source and edge select event
// [RULE12] source zero makes line b input only
// [RULE13] event triggers only when enabled
// [RULE14] output controller sets clears toggles lines
// [RULE15] decoder uses pins, disabled means bypass
// [RULE16] decoder ignores channel 0 clock routing
// [RULE17] channel 0 counts phases, 1 index
// [RULE18] speed mode drops position, keeps revolutions
// [RULE19] per-input invert and phase swap
// [RULE20] filter drops pulses under length plus one
// [RULE21] direction bit readable, follows inversion
// [RULE22] direction change after confirmed phase pattern
// [RULE23] trigger clears counter at next tick
// [RULE24] decoded direction steers channel counting
// [RULE25] pins pass two flops before edges
`include "twq_defines.vh"

module twq_timer (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // external clock pins
  input  wire [2:0]  ext_clock,
  // channel io lines, index is channel
  input  wire [1:0]  io_line_a_in,
  output wire [1:0]  io_line_a_out,
  output wire [1:0]  io_line_a_oe,
  input  wire [1:0]  io_line_b_in,
  output wire [1:0]  io_line_b_out,
  output wire [1:0]  io_line_b_oe
);

  // ========================================================
  // pin synchronisers
  reg  [6:0] sync1;
  reg  [6:0] sync2;
  reg  [6:0] sync3;
  wire [6:0] rise = sync2 & ~sync3;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
      sync3 <= 7'h00;
    end
    else
    begin
      sync1 <= {ext_clock, io_line_b_in, io_line_a_in}; // RULE25
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ========================================================
  // apb access and block registers
  reg  [15:0] bmr;
  reg         dchg_flag;
  reg  [7:0]  pre;
  wire        acc = psel & penable;
  wire        wr  = acc & pwrite;
  wire        rd  = acc & ~pwrite;
  wire [63:0] ch_rdata;
  wire [1:0]  ch_hit;
  wire        blk_hit = (paddr == `TWQ_OFF_BMR) | (paddr == `TWQ_OFF_BCR)
                        | (paddr == `TWQ_OFF_QSR);
  wire        sync_trg = wr & (paddr == `TWQ_OFF_BCR) & pwdata[`TWQ_BCR_SYNC];
  reg         dir;
  wire        dchg;

  assign pready  = 1'b1;
  assign pslverr = acc & ~(blk_hit | (|ch_hit));

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bmr       <= `TWQ_RST_BMR;
      dchg_flag <= 1'b0;
      prdata    <= 32'h0000_0000;
      pre       <= 8'h00;
    end
    else
    begin
      pre <= pre + 8'h01;
      if (wr & (paddr == `TWQ_OFF_BMR))
        bmr <= pwdata[15:0];
      if (dchg)
        dchg_flag <= 1'b1;
      else if (rd & (paddr == `TWQ_OFF_QSR))
        dchg_flag <= 1'b0;
      if (psel & ~penable)
      begin
        if (paddr == `TWQ_OFF_BMR)
          prdata <= {16'h0000, bmr};
        else if (paddr == `TWQ_OFF_QSR)
          prdata <= {30'h0, dchg_flag, dir}; // RULE21
        else if (paddr[7:5] == 3'h0)
          prdata <= ch_rdata[31:0];
        else if (paddr[7:5] == 3'h1)
          prdata <= ch_rdata[63:32];
        else
          prdata <= 32'h0000_0000;
      end
    end
  end

  // ========================================================
  // decoder input stage
  wire       qd_en  = bmr[`TWQ_BMR_DECODER_ENABLE];
  wire       pos_en = qd_en & bmr[`TWQ_BMR_POSEN] & ~bmr[`TWQ_BMR_SPEEDEN];
  wire       ina    = sync2[0] ^ bmr[`TWQ_BMR_INVERT_PHASE_A];                // RULE19
  wire       inb    = sync2[2] ^ bmr[`TWQ_BMR_INVERT_PHASE_B];                // RULE19
  wire       inx    = sync2[3] ^ bmr[`TWQ_BMR_INVERT_INDEX];              // RULE19
  wire [2:0] qraw   = bmr[`TWQ_BMR_SWAP] ? {inx, ina, inb}
                                        : {inx, inb, ina};        // RULE19
  wire [2:0] qflt;
  reg  [2:0] qold;
  genvar fi;
  generate
    for (fi = 0; fi < 3; fi = fi + 1)
    begin : g_flt
      reg       lvl;
      reg [5:0] cnt;
      assign qflt[fi] = bmr[`TWQ_BMR_FILTEN] ? lvl : qraw[fi];
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          lvl <= 1'b0;
          cnt <= 6'h00;
        end
        else if (qraw[fi] == lvl)
          cnt <= 6'h00;
        else if (cnt == bmr[`TWQ_BMR_FLEN])
        begin
          lvl <= qraw[fi];                                        // RULE20
          cnt <= 6'h00;
        end
        else
          cnt <= cnt + 6'h01;
      end
    end
  endgenerate

  // ========================================================
  // direction and direction change
  wire ea = qflt[0] ^ qold[0];
  wire eb = qflt[1] ^ qold[1];
  reg  last_b;
  reg  last_s;
  reg  suspect;
  wire ed_b = ~ea & eb;
  wire smp  = ea ? qflt[1] : qflt[0];
  assign dchg = qd_en & (ea | eb) & suspect & (last_b != ed_b);   // RULE22

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      qold    <= 3'h0;
      dir     <= 1'b0;
      last_b  <= 1'b0;
      last_s  <= 1'b0;
      suspect <= 1'b0;
    end
    else
    begin
      qold <= qflt;
      if (ea)
        dir <= qflt[0] ^ qflt[1];
      else if (eb)
        dir <= ~(qflt[0] ^ qflt[1]);
      if (ea | eb)
      begin
        last_b <= ed_b;
        last_s <= smp;
        if (last_b == ed_b)
          suspect <= suspect | (last_s == smp);                   // RULE22
        else
          suspect <= 1'b0;
      end
    end
  end

  // ========================================================
  // channel external clock 0 ticks
  wire       qd_step = pos_en & (ea | eb);                         // RULE17
  wire       idx_up  = qd_en & qflt[2] & ~qold[2];                 // RULE18
  wire [1:0] xc0_tick;
  assign xc0_tick[0] = qd_en ? qd_step                             // RULE16
                     : (bmr[`TWQ_BMR_XC0ROUTE] ? rise[1] : rise[4]);
  assign xc0_tick[1] = qd_en ? idx_up : rise[4];                   // RULE15

  // ========================================================
  // channels
  function act;
    input       cur;
    input [1:0] code;
    begin
      case (code)
        2'b01:   act = 1'b1;
        2'b10:   act = 1'b0;
        2'b11:   act = ~cur;
        default: act = cur;
      endcase
    end
  endfunction

  function ehit;
    input [1:0] code;
    input       now;
    input       old;
    begin
      ehit = ((code[0] & now & ~old) | (code[1] & ~now & old));
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_ch
      localparam [2:0] CH = gi;
      reg  [31:0] cmr;
      reg  [15:0] ra;
      reg  [15:0] rb;
      reg  [15:0] rc;
      reg  [15:0] cv;
      reg  [15:0] next_cv;
      reg         next_up;
      reg         clk_on;
      reg         run;
      reg         up;
      reg         pend;
      reg         pm_flag;
      reg         out_a;
      reg         out_b;
      reg         tick;
      wire        sel   = (paddr[7:5] == CH);
      wire        cwr   = wr & sel;
      wire        ccr   = cwr & (paddr[4:0] == `TWQ_OFF_CCR);
      wire        wave  = cmr[`TWQ_CMR_WAVE];
      wire [1:0]  wsel  = cmr[`TWQ_CMR_WSEL];
      wire [1:0]  evs   = cmr[`TWQ_CMR_EVSRC];
      wire        b_out = wave & (evs != 2'b00);                    // RULE12
      wire        qd_ch = qd_en & ~wave & ((CH == 3'h1) | pos_en);
      wire        ca    = cmr[`TWQ_CMR_ABSEL] ? sync2[gi] : sync2[gi+2];
      wire        cao   = cmr[`TWQ_CMR_ABSEL] ? sync3[gi] : sync3[gi+2];
      wire [3:0]  evn   = {sync2[6:4], sync2[gi+2]};
      wire [3:0]  evo   = {sync3[6:4], sync3[gi+2]};
      wire        cap_t = ~wave & ehit(cmr[`TWQ_CMR_EDGE], ca, cao); // RULE1 RULE2
      wire        ev    = wave & ehit(cmr[`TWQ_CMR_EDGE],
                                      evn[evs], evo[evs]);          // RULE11
      wire        sw    = (ccr & pwdata[`TWQ_CCR_SWTRG]) | sync_trg;
      wire        trig  = sw | cap_t | (ev & cmr[`TWQ_CMR_EVTRG]);  // RULE13
      wire        cnt   = tick & clk_on & run & ~pend;
      wire        m_c   = cnt & (cv == rc);
      wire        m_a   = wave & cnt & (cv == ra);
      wire        m_b   = b_out & cnt & (cv == rb);                 // RULE12
      wire [15:0] top   = wsel[1] ? rc : 16'hffff;

      assign ch_hit[gi] = sel & ((paddr[4:0] <= `TWQ_OFF_SR)
                                 & (paddr[1:0] == 2'b00));
      assign ch_rdata[32*gi +: 32] =
        (paddr[4:0] == `TWQ_OFF_CMR) ? cmr :
        (paddr[4:0] == `TWQ_OFF_RA)  ? {16'h0000, ra} :
        (paddr[4:0] == `TWQ_OFF_RB)  ? {16'h0000, rb} :
        (paddr[4:0] == `TWQ_OFF_RC)  ? {16'h0000, rc} :
        (paddr[4:0] == `TWQ_OFF_CV)  ? {16'h0000, cv} :
        (paddr[4:0] == `TWQ_OFF_SR)  ? {28'h0, up, pm_flag, run, clk_on}
                                     : 32'h0000_0000;
      assign io_line_a_out[gi] = out_a;
      assign io_line_b_out[gi] = out_b;
      assign io_line_a_oe[gi]  = wave;                              // RULE3
      assign io_line_b_oe[gi]  = b_out;                             // RULE12

      always @*
      begin
        case (cmr[`TWQ_CMR_CLKS])
          3'h0:    tick = pre[0];
          3'h1:    tick = &pre[2:0];
          3'h2:    tick = &pre[4:0];
          3'h3:    tick = &pre[6:0];
          3'h4:    tick = &pre;
          3'h5:    tick = xc0_tick[gi];
          3'h6:    tick = rise[5];
          default: tick = rise[6];
        endcase
      end

      always @*
      begin
        next_up = up;
        next_cv = cv + 16'h0001;
        if (qd_ch)
          next_cv = dir ? cv + 16'h0001 : cv - 16'h0001;          // RULE24
        else if (wave)
        begin
          case (wsel)
            2'b00:   next_cv = cv + 16'h0001;                      // RULE4 RULE5
            2'b10:   next_cv = m_c ? 16'h0000 : cv + 16'h0001;     // RULE6
            default:                                               // RULE8 RULE9
            begin
              if (up & (cv >= top))
              begin
                next_up = 1'b0;
                next_cv = cv - 16'h0001;
              end
              else if (~up & (cv == 16'h0000))
              begin
                next_up = 1'b1;
                next_cv = 16'h0001;
              end
              else
                next_cv = up ? cv + 16'h0001 : cv - 16'h0001;
            end
          endcase
        end
      end

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          cmr     <= `TWQ_RST_CMR;
          ra      <= `TWQ_RST_CNT;
          rb      <= `TWQ_RST_CNT;
          rc      <= `TWQ_RST_CNT;
          cv      <= `TWQ_RST_CNT;
          clk_on  <= 1'b0;
          run     <= 1'b0;
          up      <= 1'b1;
          pend    <= 1'b0;
          pm_flag <= 1'b0;
          out_a   <= 1'b0;
          out_b   <= 1'b0;
        end
        else
        begin
          if (cwr & (paddr[4:0] == `TWQ_OFF_CMR))
            cmr <= pwdata;
          if (cwr & (paddr[4:0] == `TWQ_OFF_RA))
            ra <= pwdata[15:0];
          if (cwr & (paddr[4:0] == `TWQ_OFF_RB))
            rb <= pwdata[15:0];
          if (cwr & (paddr[4:0] == `TWQ_OFF_RC))
            rc <= pwdata[15:0];
          if (ccr & pwdata[`TWQ_CCR_CLKDIS])
            clk_on <= 1'b0;
          else if (ccr & pwdata[`TWQ_CCR_CLKEN])
            clk_on <= 1'b1;
          else if (wave & m_c & cmr[`TWQ_CMR_CDIS])
            clk_on <= 1'b0;                                        // RULE7
          if (trig & (clk_on | (ccr & pwdata[`TWQ_CCR_CLKEN])))
            run <= 1'b1;                                           // RULE23
          else if (~clk_on | (wave & m_c & cmr[`TWQ_CMR_CSTOP]))
            run <= 1'b0;                                           // RULE7
          if (trig)
            pend <= 1'b1;                                          // RULE23
          else if (tick & clk_on)
            pend <= 1'b0;
          if (tick & clk_on & pend)
            cv <= 16'h0000;                                        // RULE23
          else if (cnt)
          begin
            cv <= next_cv;
            up <= next_up;
          end
          if (trig & wave & wsel[0])
            up <= ~up;                                             // RULE10
          if (m_c)
            pm_flag <= 1'b1;
          else if (rd & sel & (paddr[4:0] == `TWQ_OFF_SR))
            pm_flag <= 1'b0;
          if (wave)
          begin
            out_a <= act(act(act(act(out_a, m_a ? cmr[`TWQ_CMR_ACPA] : 2'b00),
                     m_c ? cmr[`TWQ_CMR_ACPC] : 2'b00),
                     ev ? cmr[`TWQ_CMR_AEEVT] : 2'b00),
                     sw ? cmr[`TWQ_CMR_ASWTRG] : 2'b00);           // RULE14
            if (b_out)
              out_b <= act(act(act(act(out_b,
                       m_b ? cmr[`TWQ_CMR_BCPB] : 2'b00),
                       m_c ? cmr[`TWQ_CMR_BCPC] : 2'b00),
                       ev ? cmr[`TWQ_CMR_BEEVT] : 2'b00),
                       sw ? cmr[`TWQ_CMR_BSWTRG] : 2'b00);         // RULE14
          end
        end
      end
    end
  endgenerate

endmodule // twq_timer

// >>> testbench/twq_timer_assertions.sv
// port assertions for the timer block
`timescale 1ns/10ps
module twq_timer_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // line enables
  input wire logic [1:0]  io_line_a_oe,
  input wire logic [1:0]  io_line_b_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================================
  // apb answer
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_wr;
    psel && penable && pwrite;
  endsequence
  property p_ready;
    s_acc |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_acc;
    pslverr |-> psel && penable;
  endproperty
  a_err_acc: assert property (p_err_acc) else $error("stray error");
  property p_err_hi;
    s_acc ##0 (paddr > 8'h48) |-> pslverr;
  endproperty
  a_err_hi: assert property (p_err_hi) else $error("no error");
  property p_err_bmr;
    s_acc ##0 (paddr == 8'h40) |-> !pslverr;
  endproperty
  a_err_bmr: assert property (p_err_bmr) else $error("false error");
  property p_hold;
    !psel |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // ====================================
  // line direction
  property p_boe;
    (io_line_b_oe & ~io_line_a_oe) == 2'h0;
  endproperty
  a_boe: assert property (p_boe) else $error("b without a");
  property p_aoe;
    $changed(io_line_a_oe) |-> $past(psel && penable && pwrite);
  endproperty
  a_aoe: assert property (p_aoe) else $error("a dir moved");
  property p_boe_wr;
    $changed(io_line_b_oe) |-> $past(psel && penable && pwrite);
  endproperty
  a_boe_wr: assert property (p_boe_wr) else $error("b dir moved");
  property p_oe_next;
    s_wr ##1 !s_acc |-> ##1 $stable(io_line_a_oe);
  endproperty
  a_oe_next: assert property (p_oe_next) else $error("late dir");
endmodule // twq_timer_chk
bind twq_timer twq_timer_chk twq_timer_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .io_line_a_oe(io_line_a_oe),
  .io_line_b_oe(io_line_b_oe));

// >>> testbench/twq_sensor.sv
// rotary sensor model driving phase and index pins
`timescale 1ns/10ps
module twq_sensor (
  // clock
  input  wire logic pclk,
  // sensor pins
  output logic      phase_a,
  output logic      phase_b,
  output logic      index
);
  initial
  begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    index = 1'b0;
  end
  // quadrature steps, a leads b when fwd, gap sets speed
  task step(input logic fwd, input int n, input int gap);
    repeat (n)
    begin
      @(posedge pclk);
      if ((phase_a == phase_b) == fwd)
        phase_a <= ~phase_a;
      else
        phase_b <= ~phase_b;
      repeat (gap) @(posedge pclk);
    end
  endtask
  // short spike on phase a
  task glitch(input int w);
    @(posedge pclk);
    phase_a <= ~phase_a;
    repeat (w) @(posedge pclk);
    phase_a <= ~phase_a;
    repeat (10) @(posedge pclk);
  endtask
  // one index pulse
  task pulse;
    @(posedge pclk);
    index <= 1'b1;
    repeat (6) @(posedge pclk);
    index <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule // twq_sensor

// >>> testbench/test_timer_waveform_quadrature_decoder.sv
// self-checking bench for the timer block
`timescale 1ns/10ps
`define chk(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("mismatch %0t got %0h exp %0h", $time, g, e); \
    end \
  end
module test_timer_waveform_quadrature_decoder;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, v, seed, rc, n;
  logic [2:0]  ext_clock;
  logic [1:0]  a_out, a_oe, b_out, b_oe;
  logic        phase_a_input, phase_b_input, idx, dec, hi, lo, e, err;
  logic [15:0] mx, prev;
  logic [7:0]  bm [4] = '{8'h03, 8'h43, 8'h0b, 8'h13};
  logic [1:0]  edg [3] = '{2'h1, 2'h0, 2'h2};
  logic [1:0]  act [3] = '{2'h1, 2'h2, 2'h2};
  int          miscompares, tests_run;
  twq_timer twq_timer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clock(ext_clock),
    .io_line_a_in({1'b0, phase_a_input}), .io_line_a_out(a_out),
    .io_line_a_oe(a_oe), .io_line_b_in({idx, phase_b_input}),
    .io_line_b_out(b_out), .io_line_b_oe(b_oe));
  twq_sensor twq_sensor_inst (
    .pclk(pclk), .phase_a(phase_a_input), .phase_b(phase_b_input), .index(idx));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ====================================
  // helpers
  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic out_after(input logic [1:0] a, input logic old);
    out_after = (a == 2'h1) ? 1'b1 : (a == 2'h2) ? 1'b0 : ~old;
  endfunction
  function logic dir_exp(input logic [7:0] m);
    dir_exp = 1'b1 ^ m[3] ^ m[4] ^ m[6];
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task sample;
    mx = 0; dec = 0; prev = 0; hi = 0; lo = 0;
    repeat (24)
    begin
      apb(1'b0, 8'h14, 0);
      dec |= (r[15:0] < prev);
      mx = (r[15:0] > mx) ? r[15:0] : mx;
      prev = r[15:0];
      hi |= (a_out[0] === 1'b1);
      lo |= (a_out[0] === 1'b0);
    end
  endtask
  task stop_test;
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    stop_test;
  end
  // ====================================
  // main sequence
  initial
  begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; ext_clock = 0; miscompares = 0; tests_run = 0;
    seed = 32'h8300;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 0); `chk(r, 32'h0)
    apb(1'b0, 8'h40, 0); `chk(r, 32'h0)
    apb(1'b0, 8'hfc, 0); `chk({err, r}, {1'b1, 32'h0})
    seed = lfsr(seed);
    rc = 4 + seed % 12;
    apb(1'b1, 8'h10, rc);
    apb(1'b1, 8'h08, 32'h2);
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, 8'h00, 32'h0009_8000 | (m << 13));
      apb(1'b1, 8'h04, 32'h5);
      repeat (4) @(posedge pclk);
      sample;
      `chk({mx > rc, dec}, (m < 2) ? 2'b10 : 2'b01)
      `chk({hi, lo, a_oe[0], b_oe[0]}, 4'b1110)
    end
    for (int b = 6; b < 8; b++)
    begin
      apb(1'b1, 8'h00, 32'h8000 | (1 << b));
      apb(1'b1, 8'h04, 32'h5);
      repeat (4 * rc + 40) @(posedge pclk);
      apb(1'b0, 8'h14, 0);
      v = r;
      apb(1'b0, 8'h18, 0);
      `chk({v[15:0], r[0]}, {rc[15:0] + 16'h1, b == 6})
    end
    e = 1'b0;
    for (int x = 1; x < 4; x++)
    begin
      apb(1'b1, 8'h00, 32'h8400 | (x << 22) | (32'(x) << 30));
      apb(1'b1, 8'h04, 32'h4);
      repeat (3) @(posedge pclk);
      e = out_after(x, e);
      `chk({a_oe[0], b_oe[0], a_out[0], b_out[0]}, {2'b11, e, e})
    end
    e = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 8'h20, 32'h9400 | (act[i] << 20) | (edg[i] << 8));
      ext_clock[0] <= 1'b1;
      repeat (5) @(posedge pclk);
      ext_clock[0] <= 1'b0;
      repeat (6) @(posedge pclk);
      e = (edg[i] == 2'h0) ? e : out_after(act[i], e);
      `chk({a_oe[1], a_out[1]}, {1'b1, e})
    end
    apb(1'b1, 8'h40, 32'h3);
    apb(1'b1, 8'h00, 32'h5);
    apb(1'b1, 8'h20, 32'h5);
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b1, 8'h24, 32'h5);
    twq_sensor_inst.step(1'b1, 4, 8);
    apb(1'b0, 8'h14, 0);
    v = r;
    seed = lfsr(seed);
    n = 4 + seed % 8;
    twq_sensor_inst.step(1'b1, n, 8);
    apb(1'b0, 8'h14, 0);
    `chk(16'(r[15:0] - v[15:0]), n[15:0])
    twq_sensor_inst.pulse;
    apb(1'b0, 8'h34, 0);
    v = r;
    twq_sensor_inst.pulse;
    twq_sensor_inst.pulse;
    apb(1'b0, 8'h34, 0);
    `chk(16'(r[15:0] - v[15:0]), 16'h2)
    foreach (bm[i])
    begin
      apb(1'b1, 8'h40, {24'h0, bm[i]});
      twq_sensor_inst.step(1'b1, 4, 8);
      apb(1'b0, 8'h48, 0);
      `chk(r[0], dir_exp(bm[i]))
    end
    apb(1'b1, 8'h40, 32'h3);
    twq_sensor_inst.step(1'b1, 4, 8);
    apb(1'b0, 8'h48, 0);
    twq_sensor_inst.step(1'b0, 6, 8);
    apb(1'b0, 8'h48, 0);
    `chk(r[1:0], 2'b10)
    apb(1'b1, 8'h40, 32'h0c83);
    twq_sensor_inst.step(1'b1, 2, 8);
    apb(1'b0, 8'h14, 0);
    v = r;
    twq_sensor_inst.glitch(2);
    apb(1'b0, 8'h14, 0);
    `chk(r[15:0], v[15:0])
    twq_sensor_inst.step(1'b1, 2, 5);
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h14, 0);
    `chk(16'(r[15:0] - v[15:0]), 16'h2)
    apb(1'b1, 8'h40, 32'h0);
    apb(1'b1, 8'h04, 32'h2);
    apb(1'b1, 8'h04, 32'h1);
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, 8'h00, (k == 0) ? 32'h300 : (k == 1) ? 32'h400 : 32'h700);
      twq_sensor_inst.glitch(6);
      apb(1'b0, 8'h18, 0);
      `chk(r[1:0], {k == 2, 1'b1})
    end
    stop_test;
  end
endmodule // test_timer_waveform_quadrature_decoder
